/* core/keypad_i2c_pkg.sv */
package keypad_i2c_pkg;

  // Fixed upper slave address bits
  localparam logic [3:0] ADDR_HIGH = 4'h7;

  // Pointer values with special increment behaviour
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] PTR_FIFO = 8'h00;
  localparam logic [7:0] PTR_KEY_FIRST = 8'h01;
  localparam logic [7:0] PTR_KEY_LAST = 8'h05;
  localparam logic [7:0] PTR_AUTOSHUT = 8'h06;
  localparam logic [7:0] PTR_GPIO_FIRST = 8'h40;
  localparam logic [7:0] PTR_GPIO_LAST = 8'h5f;

  // Soft reset locations and bits
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_GPIO_CONFIG = 8'h40;
  localparam int KEY_RESET_BIT = 7;
  localparam int GPIO_RESET_BIT = 4;

  // Bit counter positions within a nine-clock byte
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // Bus timeout: least time, rounded up to whole clock cycles
  localparam int CLK_KHZ = 25000;
  localparam int TIMEOUT_US = 20000;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * CLK_KHZ + 999) / 1000;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA
  } phase_t;

  function automatic logic [7:0] nextPointer(input logic [7:0] ptr);
    logic [7:0] res;
    res = ptr;
    if (ptr == PTR_FIFO || ptr == PTR_AUTOSHUT) begin
      res = PTR_FIFO;
    end else if ((ptr >= PTR_KEY_FIRST && ptr <= PTR_KEY_LAST) ||
                 (ptr >= PTR_GPIO_FIRST && ptr <= PTR_GPIO_LAST)) begin
      res = ptr + 8'h01;
    end
    return res;
  endfunction : nextPointer

  // Select code: 0 ground, 1 supply, 2 data line, 3 clock line
  function automatic logic [6:0] ownAddress(input logic [1:0] sel);
    return {ADDR_HIGH, sel, 1'b0};
  endfunction : ownAddress

endpackage : keypad_i2c_pkg

/* core/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync
  import keypad_i2c_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync width must be at least one");
    end
  endgenerate

  // A change is taken only once the last two stages agree
  always_comb begin
    s_next = s_reg;
    s_next.stage1 = din;
    s_next.stage2 = s_reg.stage1;
    s_next.stage3 = s_reg.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_reg.stage2[i] == s_reg.stage3[i]) begin
        s_next.level[i] = s_reg.stage3[i];
      end
    end
  end

  // Idle bus lines sit high, so reset to high avoids a false edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.level;

endmodule : pin_sync

/* core/keypad_i2c_slave.sv */
// Overview of operation
// - Transfer: START, 7-bit address plus direction, pointer byte, data, STOP.
// - START is SDA falling, STOP SDA rising, both while SCL high.
// - SCL is input only; SDA is driven only as open-drain pull-down.
// - Device acknowledges received bytes by holding SDA low on ninth clock.
// - Address is 0111 then select-pin code: 000, 010, 100, 110.
// - Eighth bit after START is direction: zero write, one read.
// - Device watches for START plus own address and acknowledges it.
// - SCL low beyond 20ms aborts the transfer and releases SDA.
// - After timeout abort, ignore the bus until a new START.
// - Software can switch the bus timeout on and off.
// - First write byte becomes the pointer; STOP then changes nothing else.
// - First data byte goes to pointer register, later ones follow increments.
// - Reads start at the retained pointer and advance per byte.
// - Pointer 0x00 stays, 0x06 wraps to 0x00, 0x01-0x05, 0x40-0x5F increment.
// - Writing D7 at 0x01 resets only the key-scan state.
// - Writing D4 at 0x40 resets the GPIO logic.
`timescale 1ns/10ps
module keypad_i2c_slave
  import keypad_i2c_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [1:0] addressSelectPin,
  input wire logic timeoutEnable,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData,
  output logic keyScanReset,
  output logic gpioReset,
  output logic busTimeout
);

  localparam int TW = $clog2(TIMEOUT_LIMIT + 1);

  generate
    if (TIMEOUT_LIMIT < 1) begin : g_bad_timeout
      $error("TIMEOUT_LIMIT must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    phase_t phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic [7:0] wrData;
    logic isRead;
    logic sdaOe;
    logic wrStrobe;
    logic rdStrobe;
    logic keyReset;
    logic gpioReset;
    logic timedOut;
    logic [TW-1:0] lowCnt;
    logic sclPrev;
    logic sdaPrev;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [1:0] rstPipe;
  logic rstn;
  logic [3:0] pinLevels;
  logic scl;
  logic sda;
  logic [1:0] addrSel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic addrMatch;
  logic lowLimit;

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];

  pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({sclIn, sdaIn, addressSelectPin}),
    .dout(pinLevels)
  );

  assign scl = pinLevels[3];
  assign sda = pinLevels[2];
  assign addrSel = pinLevels[1:0];

  assign sclRise = scl && !s_reg.sclPrev;
  assign sclFall = !scl && s_reg.sclPrev;
  assign startSeen = scl && s_reg.sclPrev && s_reg.sdaPrev && !sda;
  assign stopSeen = scl && s_reg.sclPrev && !s_reg.sdaPrev && sda;
  assign addrMatch = s_reg.shift[7:1] == ownAddress(addrSel);
  assign lowLimit = s_reg.lowCnt == TW'(TIMEOUT_LIMIT - 1);

  always_comb begin
    s_next = s_reg;
    s_next.sclPrev = scl;
    s_next.sdaPrev = sda;
    s_next.wrStrobe = 1'b0;
    s_next.rdStrobe = 1'b0;
    s_next.keyReset = 1'b0;
    s_next.gpioReset = 1'b0;
    s_next.timedOut = 1'b0;
    // Read data is taken at the edge that ends the read strobe
    if (s_reg.rdStrobe) begin
      s_next.shift = regRdData;
    end
    // Pointer moves only after the written byte has been handed over
    if (s_reg.wrStrobe) begin
      s_next.pointer = nextPointer(s_reg.pointer);
      s_next.keyReset = s_reg.pointer == PTR_CONFIG &&
                        s_reg.wrData[KEY_RESET_BIT];
      s_next.gpioReset = s_reg.pointer == PTR_GPIO_CONFIG &&
                         s_reg.wrData[GPIO_RESET_BIT];
    end
    if (timeoutEnable && s_reg.phase != ST_IDLE && !scl) begin
      s_next.lowCnt = s_reg.lowCnt + 1'b1;
    end else begin
      s_next.lowCnt = '0;
    end
    if (startSeen) begin
      // Repeated START also lands here, keeping the pointer
      s_next.phase = ST_ADDR;
      s_next.bitCnt = 4'h0;
      s_next.sdaOe = 1'b0;
      s_next.lowCnt = '0;
    end else if (stopSeen) begin
      s_next.phase = ST_IDLE;
      s_next.bitCnt = 4'h0;
      s_next.sdaOe = 1'b0;
    end else if (timeoutEnable && s_reg.phase != ST_IDLE && lowLimit) begin
      s_next.phase = ST_IDLE;
      s_next.bitCnt = 4'h0;
      s_next.sdaOe = 1'b0;
      s_next.timedOut = 1'b1;
      s_next.lowCnt = '0;
    end else if (sclRise) begin
      case (s_reg.phase)
        ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA: begin
          if (s_reg.bitCnt < BIT_ACK) begin
            // Sample on the rising edge; master keeps data stable
            s_next.shift = {s_reg.shift[6:0],
                            s_reg.phase == ST_RDATA ? 1'b0 : sda};
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end else if (s_reg.phase == ST_RDATA &&
                       s_reg.bitCnt == BIT_ACK) begin
            s_next.pointer = nextPointer(s_reg.pointer);
            if (sda) begin
              s_next.phase = ST_IDLE;
              s_next.bitCnt = 4'h0;
            end else begin
              s_next.rdStrobe = 1'b1;
              s_next.bitCnt = BIT_DONE;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (s_reg.phase)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (s_reg.bitCnt == BIT_ACK) begin
            s_next.bitCnt = BIT_DONE;
            s_next.sdaOe = 1'b1;
            if (s_reg.phase == ST_ADDR) begin
              if (addrMatch) begin
                s_next.isRead = s_reg.shift[0];
                s_next.rdStrobe = s_reg.shift[0];
              end else begin
                s_next.phase = ST_IDLE;
                s_next.bitCnt = 4'h0;
                s_next.sdaOe = 1'b0;
              end
            end else if (s_reg.phase == ST_CMD) begin
              s_next.pointer = s_reg.shift;
            end else begin
              s_next.wrStrobe = 1'b1;
              s_next.wrData = s_reg.shift;
            end
          end else if (s_reg.bitCnt == BIT_DONE) begin
            s_next.bitCnt = 4'h0;
            s_next.sdaOe = 1'b0;
            if (s_reg.phase == ST_ADDR) begin
              if (s_reg.isRead) begin
                s_next.phase = ST_RDATA;
                s_next.sdaOe = !s_reg.shift[7];
              end else begin
                s_next.phase = ST_CMD;
              end
            end else begin
              s_next.phase = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (s_reg.bitCnt == BIT_ACK) begin
            s_next.sdaOe = 1'b0;
          end else begin
            if (s_reg.bitCnt == BIT_DONE) begin
              s_next.bitCnt = 4'h0;
            end
            s_next.sdaOe = !s_reg.shift[7];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Only a pull-down is ever driven; there is no clock output at all
  assign sdaOut = 1'b0;
  assign sdaOe = s_reg.sdaOe;
  assign regAddr = s_reg.pointer;
  assign regWrData = s_reg.wrData;
  assign regWrite = s_reg.wrStrobe;
  assign regRead = s_reg.rdStrobe;
  assign keyScanReset = s_reg.keyReset;
  assign gpioReset = s_reg.gpioReset;
  assign busTimeout = s_reg.timedOut;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  pulldown_only_a: assert property (sdaOut == 1'b0)
    else $error("SDA driven high");

  start_enters_addr_a: assert property (
    startSeen |=> s_reg.phase == ST_ADDR && s_reg.bitCnt == 4'h0 &&
    !sdaOe)
    else $error("START did not restart address phase");

  stop_goes_idle_a: assert property (
    stopSeen && !startSeen |=> s_reg.phase == ST_IDLE && !sdaOe)
    else $error("STOP did not return to idle");

  addr_ack_a: assert property (
    sclFall && s_reg.phase == ST_ADDR && s_reg.bitCnt == BIT_ACK &&
    addrMatch && !startSeen && !stopSeen && !lowLimit
    |=> sdaOe && s_reg.bitCnt == BIT_DONE)
    else $error("Own address not acknowledged");

  addr_miss_a: assert property (
    sclFall && s_reg.phase == ST_ADDR && s_reg.bitCnt == BIT_ACK &&
    !addrMatch && !startSeen && !stopSeen && !lowLimit
    |=> !sdaOe && s_reg.phase == ST_IDLE)
    else $error("Foreign address not ignored");

  ack_held_a: assert property (
    $rose(sdaOe) && s_reg.bitCnt == BIT_DONE && s_reg.phase != ST_RDATA
    |-> sdaOe until (sclFall || startSeen || stopSeen || lowLimit))
    else $error("Acknowledge released early");

  timeout_abort_a: assert property (
    timeoutEnable && s_reg.phase != ST_IDLE && lowLimit && !startSeen &&
    !stopSeen |=> !sdaOe && s_reg.phase == ST_IDLE && busTimeout)
    else $error("Bus timeout did not abort");

  timeout_off_a: assert property (
    !timeoutEnable |=> s_reg.lowCnt == '0)
    else $error("Timeout counted while disabled");

  idle_quiet_a: assert property (
    s_reg.phase == ST_IDLE && !startSeen |=> s_reg.phase == ST_IDLE &&
    !sdaOe)
    else $error("Idle left without START");

  pointer_load_a: assert property (
    sclFall && s_reg.phase == ST_CMD && s_reg.bitCnt == BIT_ACK &&
    !startSeen && !stopSeen && !lowLimit
    |=> s_reg.pointer == $past(s_reg.shift))
    else $error("Pointer byte not stored");

  pointer_step_a: assert property (
    regWrite |=> regAddr == nextPointer($past(regAddr)))
    else $error("Pointer increment wrong");

  key_reset_a: assert property (
    regWrite && regAddr == PTR_CONFIG && regWrData[KEY_RESET_BIT]
    |=> keyScanReset && !gpioReset)
    else $error("Key-scan reset missing");

  write_cov_c: cover property (regWrite ##[1:1000] stopSeen);
  read_cov_c: cover property (regRead ##[1:1000] regRead);
  timeout_cov_c: cover property (busTimeout);
  miss_cov_c: cover property (
    sclFall && s_reg.phase == ST_ADDR && s_reg.bitCnt == BIT_ACK &&
    !addrMatch);

endmodule : keypad_i2c_slave

/* test/i2c_master_model.sv */
`timescale 1ns/10ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaDrv
);
  // Lines idle released high; SCL stands still between frames
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Repeated START raises both lines first
  task automatic start();
    if (scl == 1'b0) begin
      tick(3);
      sdaDrv = 1'b1;
      tick(3);
      scl = 1'b1;
    end
    tick(3);
    sdaDrv = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(3);
    sdaDrv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    sdaDrv = 1'b1;
    tick(3);
  endtask : stop

  // Low six cycles, high two: the slave's sync lag fits the low phase
  task automatic bitIo(input logic b, output logic r);
    tick(3);
    sdaDrv = b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sdaWire;
    scl = 1'b0;
  endtask : bitIo

  // MSB first, ninth clock carries the acknowledge
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask : writeByte

  task automatic readByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(last, r);
  endtask : readByte
endmodule : i2c_master_model

/* test/keypad_i2c_slave_tb_top.sv */
`timescale 1ns/10ps
module keypad_i2c_slave_tb_top;
  logic clk;
  logic resetn;
  logic scl;
  logic sdaDrv;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic [1:0] sel;
  logic timeoutEnable;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdData;
  logic keyScanReset;
  logic gpioReset;
  logic busTimeout;
  int mismatches = 0;
  int nTests = 0;
  int keyCnt = 0;
  int gpioCnt = 0;
  int toCnt = 0;
  logic [7:0] wrA[$];
  logic [7:0] wrD[$];

  always #20 clk = ~clk;
  // Pull-up wire: low whenever either party pulls
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);

  keypad_i2c_slave #(.TIMEOUT_LIMIT(200)) dut_u (
    .clk(clk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectPin(sel),
    .timeoutEnable(timeoutEnable), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .keyScanReset(keyScanReset),
    .gpioReset(gpioReset), .busTimeout(busTimeout)
  );
  i2c_master_model master_u (
    .clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv)
  );

  // Map stand-in: data is address xor 0x5a, set up within the strobe's
  // cycle, since the slave latches it at the edge that ends the strobe
  always @(posedge clk) begin
    #1;
    if (regRead === 1'b1) regRdData = regAddr ^ 8'h5a;
  end

  always @(posedge clk) begin
    if (regWrite === 1'b1) wrA.push_back(regAddr);
    if (regWrite === 1'b1) wrD.push_back(regWrData);
    if (keyScanReset === 1'b1) keyCnt++;
    if (gpioReset === 1'b1) gpioCnt++;
    if (busTimeout === 1'b1) toCnt++;
  end

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpByte

  task automatic cmpBit(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpBit

  function automatic logic [7:0] nxt(input logic [7:0] p);
    if (p == 8'h00 || p == 8'h06) return 8'h00;
    if ((p >= 8'h01 && p <= 8'h05) || (p >= 8'h40 && p <= 8'h5f))
      return p + 8'h01;
    return p;
  endfunction : nxt

  function automatic logic [7:0] own(input logic rw);
    return {4'h7, sel, 1'b0, rw};
  endfunction : own

  task automatic addrScan();
    logic a;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      master_u.tick(8);
      master_u.start();
      master_u.writeByte({4'h7, sel + 2'd1, 2'b00}, a);
      cmpBit(a, 1'b0);
      master_u.writeByte(own(1'b0), a);
      cmpBit(a, 1'b0);
      master_u.start();
      master_u.writeByte(own(1'b0), a);
      cmpBit(a, 1'b1);
      master_u.stop();
    end
    sel = 2'd1;
    master_u.tick(8);
  endtask : addrScan

  task automatic doWrite(input logic [7:0] ptr, input int n);
    logic a;
    logic [7:0] p;
    p = ptr;
    wrA.delete();
    wrD.delete();
    master_u.start();
    master_u.writeByte(own(1'b0), a);
    cmpBit(a, 1'b1);
    master_u.writeByte(ptr, a);
    cmpBit(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      master_u.writeByte(8'ha0 + 8'(i), a);
      cmpBit(a, 1'b1);
    end
    master_u.stop();
    master_u.tick(4);
    cmpByte(8'(wrA.size()), 8'(n));
    for (int i = 0; i < wrA.size(); i++) begin
      cmpByte(wrA[i], p);
      cmpByte(wrD[i], 8'ha0 + 8'(i));
      p = nxt(p);
    end
  endtask : doWrite

  task automatic doRead(input logic [7:0] ptr, input int n);
    logic a;
    logic [7:0] d;
    logic [7:0] p;
    p = ptr;
    master_u.start();
    master_u.writeByte(own(1'b0), a);
    master_u.writeByte(ptr, a);
    master_u.start();
    master_u.writeByte(own(1'b1), a);
    cmpBit(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      master_u.readByte(i == n - 1, d);
      cmpByte(d, p ^ 8'h5a);
      p = nxt(p);
    end
    master_u.stop();
  endtask : doRead

  task automatic softReset(input logic [7:0] ptr, input logic [7:0] d,
                           input int ek, input int eg);
    logic a;
    int k;
    int g;
    k = keyCnt;
    g = gpioCnt;
    master_u.start();
    master_u.writeByte(own(1'b0), a);
    master_u.writeByte(ptr, a);
    master_u.writeByte(d, a);
    master_u.stop();
    cmpByte(8'(keyCnt - k), 8'(ek));
    cmpByte(8'(gpioCnt - g), 8'(eg));
  endtask : softReset

  // Pointer 0x10 holds, its data 0x4a makes the slave pull bit 7 low
  task automatic timeoutTest();
    logic a;
    int c;
    master_u.start();
    master_u.writeByte(own(1'b1), a);
    master_u.tick(8);
    cmpBit(sdaOe, 1'b1);
    cmpBit(sdaOut, 1'b0);
    c = toCnt;
    master_u.tick(260);
    cmpByte(8'(toCnt - c), 8'h01);
    cmpBit(sdaOe, 1'b0);
    master_u.writeByte(own(1'b0), a);
    cmpBit(a, 1'b0);
    master_u.stop();
    master_u.start();
    master_u.writeByte(own(1'b0), a);
    cmpBit(a, 1'b1);
    timeoutEnable = 1'b0;
    c = toCnt;
    master_u.tick(260);
    cmpByte(8'(toCnt - c), 8'h00);
    master_u.writeByte(8'h10, a);
    cmpBit(a, 1'b1);
    master_u.stop();
    timeoutEnable = 1'b1;
  endtask : timeoutTest

  // Reset in mid-read: bus released, pointer back to zero
  task automatic resetTest();
    logic a;
    logic [7:0] d;
    master_u.start();
    master_u.writeByte(own(1'b1), a);
    master_u.tick(8);
    cmpBit(sdaOe, 1'b1);
    resetn = 1'b0;
    master_u.tick(2);
    cmpBit(sdaOe, 1'b0);
    cmpByte(regAddr, 8'h00);
    resetn = 1'b1;
    master_u.tick(12);
    master_u.start();
    master_u.writeByte(own(1'b1), a);
    cmpBit(a, 1'b1);
    master_u.readByte(1'b1, d);
    cmpByte(d, 8'h5a);
    master_u.stop();
  endtask : resetTest

  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    sel = 2'd1;
    timeoutEnable = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    master_u.tick(12);
    addrScan();
    doWrite(8'h04, 3);
    doWrite(8'h00, 2);
    doWrite(8'h06, 2);
    doWrite(8'h5e, 3);
    doWrite(8'h07, 2);
    doWrite(8'h10, 0);
    doRead(8'h05, 3);
    doRead(8'h5f, 2);
    softReset(8'h01, 8'h80, 1, 0);
    softReset(8'h01, 8'h7f, 0, 0);
    softReset(8'h40, 8'h10, 0, 1);
    softReset(8'h40, 8'hef, 0, 0);
    doWrite(8'h10, 0);
    timeoutTest();
    resetTest();
    summarize();
  end

  // Tests need about 6000 cycles; a hang is cut off well beyond that
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : keypad_i2c_slave_tb_top
